// ---- hw/uvs_pkg.sv ----
// shared constants and carriers of the undervoltage stage timing block
// assumes a 125 MHz clock and a processing cycle derived from it

package uvs_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned CYCLE_US = 5000; // processing cycle, 5 ms
  localparam int unsigned TICK_CLKS = CYCLE_US * 1000 / CLK_NS;
  localparam int unsigned TCW = 24; // tick counter width

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_USET = 8'h04;
  localparam logic [7:0] A_UBLK = 8'h08;
  localparam logic [7:0] A_FIXED_DLY = 8'h0C;
  localparam logic [7:0] A_KDIAL = 8'h10;
  localparam logic [7:0] A_AEXP = 8'h14;
  localparam logic [7:0] A_REL = 8'h18;
  localparam logic [7:0] A_SCALE = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_TREM = 8'h24;
  localparam logic [7:0] A_TEXP = 8'h28;
  localparam logic [7:0] A_RAT0 = 8'h2C;
  localparam logic [7:0] A_RAT1 = 8'h30;
  localparam logic [7:0] A_RAT2 = 8'h34;
  localparam logic [7:0] A_RMIN = 8'h38;
  localparam logic [7:0] A_PLVL = 8'h3C;
  localparam logic [7:0] A_BLVL = 8'h40;

  // ------------------------------------------------------------
  // control bit positions and reset values
  // ------------------------------------------------------------
  localparam int unsigned C_INV_MODE = 0;
  localparam int unsigned C_DLYREL = 1;
  localparam int unsigned C_RSTREL = 2;
  localparam int unsigned C_CONT = 3;
  localparam logic [3:0] CTRL_RST = 4'h6;
  localparam logic [15:0] USET_RST = 16'h1770; // 60.00 %Un
  localparam logic [15:0] UBLK_RST = 16'h03E8; // 10.00 %Un
  localparam logic [15:0] FIXED_DLY_RST = 16'h0008; // 0.040 s in 5 ms steps
  localparam logic [15:0] KDIAL_RST = 16'h0005; // 0.05 s
  localparam logic [15:0] AEXP_RST = 16'h0064; // 1.00
  localparam logic [15:0] REL_RST = 16'h000C; // 0.060 s in 5 ms steps
  localparam logic [31:0] SCALE_RST = 32'h0014_0000; // plain default

  // ------------------------------------------------------------
  // fixed point figures (Q16, exponent in 0.01 steps, 0.01-step scale)
  // ------------------------------------------------------------
  localparam logic [16:0] ONE_Q16 = 17'h1_0000;
  localparam logic [31:0] REL_RATIO_Q16 = 32'h0001_07AE; // 103 %
  localparam logic [16:0] FRAC_Q16 = 17'h0_028F; // 0.01 in Q16
  localparam logic [15:0] A_UNIT = 16'h0064; // exponent 1.00
  localparam logic [63:0] CENT = 64'h64; // ratio to 0.01 steps

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] m2;
    logic [15:0] m1;
    logic [15:0] m0;
  } uvs_meas_t;

  typedef struct packed {
    logic start;
    logic blocked;
    logic trip;
  } uvs_flags_t;

  typedef struct packed {
    logic [3:0] ctrl;
    logic [15:0] uset;
    logic [15:0] ublk;
    logic [15:0] fixed_dly;
    logic [15:0] kdial;
    logic [15:0] aexp;
    logic [15:0] rel;
    logic [31:0] scale;
  } uvs_cfg_t;

  localparam uvs_cfg_t CFG_RST = '{ctrl: CTRL_RST, uset: USET_RST,
    ublk: UBLK_RST, fixed_dly: FIXED_DLY_RST, kdial: KDIAL_RST, aexp: AEXP_RST,
    rel: REL_RST, scale: SCALE_RST};

endpackage

// ---- hw/uvs_stage.sv ----
// undervoltage stage: pick-up, blocking, operate and release timing
// assumes synchronous inputs, magnitudes in 0.01 %Un, one 125 MHz clock
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module uvs_stage #(
  parameter int unsigned TICK_CLKS = uvs_pkg::TICK_CLKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [uvs_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire uvs_pkg::uvs_meas_t meas,
  input wire logic blk_in,
  output uvs_pkg::uvs_flags_t flags
);
  import uvs_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_DIV = 4'h2,
    E_POW = 4'h4,
    E_FIN = 4'h8
  } uvs_eng_t;

  typedef struct packed {
    uvs_eng_t st;
    logic [TCW-1:0] tcnt;
    uvs_cfg_t cfg;
    uvs_meas_t m;
    logic blk;
    logic [2:0] jb;
    logic [4:0] bcnt;
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] quo;
    logic [32:0] rem;
    logic [16:0] pw;
    logic [15:0] acnt;
    logic [2:0][31:0] rat;
    logic [31:0] texp_i;
    logic [31:0] trem_i;
    logic [31:0] texp;
    logic [31:0] trem;
    logic [31:0] acc;
    logic [15:0] rcnt;
    logic pick;
    logic de;
    logic rel_run;
    uvs_flags_t fl;
    logic [31:0] rdata;
  } uvs_state_t;

  localparam uvs_state_t S_RST = '{st: E_IDLE, cfg: CFG_RST, default: '0};
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CLKS - 1);

  uvs_state_t s;
  uvs_state_t n;

  // ------------------------------------------------------------
  // arithmetic helpers
  // ------------------------------------------------------------

  // q16 product, both operands at most 1.0
  function automatic logic [16:0] qmul(input logic [16:0] a, input logic [16:0] b);
    logic [33:0] p;
    p = a * b;
    return p[32:16];
  endfunction

  // q16 ratio to 0.01 steps
  function automatic logic [31:0] cent(input logic [31:0] q);
    logic [63:0] p;
    p = {32'h0, q} * CENT;
    return p[47:16];
  endfunction

  // setting in 0.01 %Un to primary 0.1 V
  function automatic logic [31:0] lvl(input logic [15:0] u, input logic [31:0] sc);
    logic [47:0] p;
    p = u * sc;
    return p[47:16];
  endfunction

  // numerator and divisor of each divider job
  function automatic logic [63:0] job(input logic [2:0] j, input uvs_meas_t m,
      input logic [15:0] us, input logic [31:0] kq, input logic [31:0] acc,
      input logic [16:0] omp);
    logic [31:0] nm;
    logic [31:0] dn;
    dn = {16'h0, us};
    case (j)
      3'h0: nm = {m.m0, 16'h0};
      3'h1: nm = {m.m1, 16'h0};
      3'h2: nm = {m.m2, 16'h0};
      3'h3: nm = kq;
      default: nm = (acc < kq) ? kq - acc : 32'h0;
    endcase
    if (j >= 3'h3) begin
      dn = {15'h0, omp};
    end
    return {nm, dn};
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic tick;
    logic [32:0] rw;
    logic ge;
    logic [31:0] q;
    logic [31:0] rmin;
    logic [15:0] mmin;
    logic [16:0] r17;
    logic [16:0] fr;
    logic [31:0] kq;
    logic [63:0] jd;
    logic ld;
    logic [2:0] ldj;
    logic act, inv_mode, pk, de, done, adv, inrel;
    logic [31:0] inc, lim, acc;
    logic [15:0] rc;
    tick = 1'b0;
    ld = 1'b0;
    ldj = 3'h0;
    jd = 64'h0;
    rw = 33'h0;
    ge = 1'b0;
    q = 32'h0;
    rmin = 32'h0;
    mmin = 16'h0;
    r17 = 17'h0;
    fr = 17'h0;
    kq = 32'h0;
    inv_mode = 1'b0;
    act = 1'b0;
    pk = 1'b0;
    de = 1'b0;
    done = 1'b0;
    adv = 1'b0;
    inrel = 1'b0;
    inc = 32'h0;
    lim = 32'h0;
    acc = 32'h0;
    rc = 16'h0;
    n = s;
    n.rdata = 32'h0;

    // time dial in 10 ms steps, q16 scaled
    kq = {s.cfg.kdial[14:0], 17'h0};
    inv_mode = s.cfg.ctrl[C_INV_MODE];

    // lowest ratio and lowest magnitude
    rmin = s.rat[0];
    if (s.rat[1] < rmin) begin
      rmin = s.rat[1];
    end
    if (s.rat[2] < rmin) begin
      rmin = s.rat[2];
    end
    mmin = s.m.m0;
    if (s.m.m1 < mmin) begin
      mmin = s.m.m1;
    end
    if (s.m.m2 < mmin) begin
      mmin = s.m.m2;
    end
    // ratio at or above 1.0 makes no inverse-time progress
    r17 = (rmin >= {15'h0, ONE_Q16}) ? ONE_Q16 : rmin[16:0];
    fr = 17'(s.acnt[6:0]) * FRAC_Q16;

    // processing cycle divider
    if (s.tcnt == TICK_LAST) begin
      n.tcnt = '0;
      tick = 1'b1;
    end else begin
      n.tcnt = s.tcnt + 1'b1;
    end

    // restoring divider step, one quotient bit per clock
    rw = {s.rem[31:0], s.num[31]};
    ge = rw >= {1'b0, s.den};
    q = {s.quo[30:0], ge};

    // math engine, then one evaluation per cycle
    unique case (s.st)
      E_IDLE: begin
        if (tick) begin
          n.blk = blk_in;
          n.m = meas;
          ld = 1'b1;
          ldj = 3'h0;
        end
      end
      E_DIV: begin
        n.num = {s.num[30:0], 1'b0};
        n.rem = ge ? rw - {1'b0, s.den} : rw;
        n.quo = q;
        n.bcnt = s.bcnt + 5'h1;
        if (s.bcnt == 5'h1F) begin
          case (s.jb)
            3'h3: n.texp_i = q;
            3'h4: n.trem_i = q;
            default: n.rat[s.jb[1:0]] = q;
          endcase
          if (s.jb == 3'h2) begin
            n.st = E_POW;
            n.pw = ONE_Q16;
            n.acnt = s.cfg.aexp;
          end else if (s.jb == 3'h4) begin
            n.st = E_FIN;
          end else begin
            ld = 1'b1;
            ldj = s.jb + 3'h1;
          end
        end
      end
      E_POW: begin
        // whole powers by repeated product, fraction by linear blend
        if (s.acnt >= A_UNIT) begin
          n.pw = qmul(s.pw, r17);
          n.acnt = s.acnt - A_UNIT;
        end else begin
          n.pw = s.pw - qmul(qmul(s.pw, ONE_Q16 - r17), fr);
          ld = 1'b1;
          ldj = 3'h3;
        end
      end
      E_FIN: begin
        n.st = E_IDLE;
        // pick-up with built-in hysteresis
        pk = s.pick;
        if (rmin < {15'h0, ONE_Q16}) begin
          pk = 1'b1;
        end else if (rmin > REL_RATIO_Q16) begin
          pk = 1'b0;
        end
        // de-energized block, released above pick-up or when ublk is zero
        de = s.de;
        if (s.cfg.ublk == 16'h0) begin
          de = 1'b0;
        end else if (mmin < s.cfg.ublk) begin
          de = 1'b1;
        end else if (rmin > {15'h0, ONE_Q16}) begin
          de = 1'b0;
        end
        n.pick = pk;
        n.de = de;
        act = pk & ~de & ~s.blk;
        n.fl.blocked = pk & (s.blk | de);
        // per-cycle progress: one step, or 1 - ratio^a in q16
        inc = inv_mode ? {15'h0, ONE_Q16 - s.pw} : 32'h1;
        lim = inv_mode ? kq : {16'h0, s.cfg.fixed_dly};
        acc = s.acc;
        adv = 1'b0;
        inrel = s.fl.start | s.rel_run;
        rc = s.rel_run ? s.rcnt + 16'h1 : 16'h1;
        done = rc >= s.cfg.rel;
        if (act) begin
          n.fl.start = 1'b1;
          n.rel_run = 1'b0;
          n.rcnt = 16'h0;
          adv = 1'b1;
          acc = s.acc + inc;
        end else if (inrel) begin
          n.rcnt = rc;
          n.rel_run = ~done;
          n.fl.start = s.cfg.ctrl[C_DLYREL] & ~done;
          if (s.cfg.ctrl[C_CONT] & ~done) begin
            adv = 1'b1;
            acc = s.acc + inc;
          end else if (done | ~s.cfg.ctrl[C_RSTREL]) begin
            acc = 32'h0;
          end
        end else begin
          acc = 32'h0;
        end
        n.acc = acc;
        // fixed delay of zero trips with start, else on the count reaching it
        n.fl.trip = adv & (acc >= lim);
        n.trem = adv ? (inv_mode ? s.trem_i : lim - acc) : 32'h0;
        n.texp = inv_mode ? s.texp_i : {16'h0, s.cfg.fixed_dly};
      end
      default: n.st = E_IDLE;
    endcase

    // start a divider job, using the fresh power for the timer jobs
    if (ld) begin
      jd = job(ldj, n.m, s.cfg.uset, kq, s.acc, ONE_Q16 - n.pw);
      n.num = jd[63:32];
      n.den = jd[31:0];
      n.quo = 32'h0;
      n.rem = 33'h0;
      n.bcnt = 5'h0;
      n.jb = ldj;
      n.st = E_DIV;
    end

    // register writes
    if (wr) begin
      case (addr)
        A_CTRL: n.cfg.ctrl = wdata[3:0];
        A_USET: n.cfg.uset = wdata[15:0];
        A_UBLK: n.cfg.ublk = wdata[15:0];
        A_FIXED_DLY: n.cfg.fixed_dly = wdata[15:0];
        A_KDIAL: n.cfg.kdial = wdata[15:0];
        A_AEXP: n.cfg.aexp = wdata[15:0];
        A_REL: n.cfg.rel = wdata[15:0];
        A_SCALE: n.cfg.scale = wdata;
        default: ;
      endcase
    end

    // register reads, unmapped offsets read zero
    if (rd) begin
      case (addr)
        A_CTRL: n.rdata = {28'h0, s.cfg.ctrl};
        A_USET: n.rdata = {16'h0, s.cfg.uset};
        A_UBLK: n.rdata = {16'h0, s.cfg.ublk};
        A_FIXED_DLY: n.rdata = {16'h0, s.cfg.fixed_dly};
        A_KDIAL: n.rdata = {16'h0, s.cfg.kdial};
        A_AEXP: n.rdata = {16'h0, s.cfg.aexp};
        A_REL: n.rdata = {16'h0, s.cfg.rel};
        A_SCALE: n.rdata = s.cfg.scale;
        A_STAT: n.rdata = {26'h0, s.rel_run, s.de, s.pick, s.fl.trip, s.fl.blocked, s.fl.start};
        A_TREM: n.rdata = s.trem;
        A_TEXP: n.rdata = s.texp;
        A_RAT0: n.rdata = cent(s.rat[0]);
        A_RAT1: n.rdata = cent(s.rat[1]);
        A_RAT2: n.rdata = cent(s.rat[2]);
        A_RMIN: n.rdata = cent(rmin);
        A_PLVL: n.rdata = lvl(s.cfg.uset, s.cfg.scale);
        A_BLVL: n.rdata = lvl(s.cfg.ublk, s.cfg.scale);
        default: n.rdata = 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register, frozen while ce is low, except that rst loads the reset state whatever ce is
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= S_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign rdata = s.rdata;
  assign flags = s.fl;

endmodule

// ---- dv/uvs_stage_props.sv ----
// port-level assertions for the undervoltage stage
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module uvs_stage_props
  import uvs_pkg::*;
#(
  parameter int unsigned TICK_CLKS = 256
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire uvs_pkg::uvs_flags_t flags
);
  // ----------------
  // helper logic
  // ----------------
  uvs_flags_t prev_r;
  logic [15:0] gap_r;
  // cycles since the last flag change, saturating so it never wraps
  always_ff @(posedge clk) begin
    prev_r <= flags;
    if (rst || flags != prev_r) begin
      gap_r <= '0;
    end else if (ce && gap_r != 16'hFFFF) begin
      gap_r <= gap_r + 16'h1;
    end
  end

  // ----------------
  // assertions
  // ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_ONE_EVAL_PER_TICK: assert property ((flags != prev_r) |-> (gap_r >= 16'(TICK_CLKS / 2)))
    else $error("flags changed twice within one tick");
  AST_TRIP_HAS_START: assert property ($rose(flags.trip) |-> (flags.start || $past(flags.start)))
    else $error("trip rose without start");
  AST_NO_TRIP_BLOCKED: assert property ($rose(flags.trip) |-> !flags.blocked)
    else $error("trip rose while blocked");
  AST_START_UNBLOCKED: assert property ($rose(flags.start) |-> !flags.blocked)
    else $error("start rose while blocked");
  AST_FLAGS_FROZEN: assert property (!ce |=> $stable(flags))
    else $error("flags moved with enable low");
  AST_RDATA_FROZEN: assert property (!ce |=> $stable(rdata))
    else $error("read data moved with enable low");
  AST_RDATA_IDLE: assert property ((ce && !rd) |=> (rdata == '0))
    else $error("read data not zero after idle cycle");
  AST_RESET_CLEARS: assert property (disable iff (1'b0) (rst && ce) |=> (flags == '0 && rdata == '0))
    else $error("outputs not cleared by reset");
endmodule

bind uvs_stage uvs_stage_props #(.TICK_CLKS(TICK_CLKS)) u_props (
  .clk(clk), .rst(rst), .ce(ce), .rd(rd), .rdata(rdata), .flags(flags)
);

// ---- dv/uvs_blk_model.sv ----
// blocking matrix stand-in driving the stage block input
// assumes the bench raises the request well ahead of any expiry
`timescale 1ns/1ps
module uvs_blk_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic blk_req,
  output logic blk_in
);
  // registered like a matrix output; one cycle is far inside the bench's 15-cycle lead
  always_ff @(posedge clk) begin
    if (rst) begin
      blk_in <= 1'b0;
    end else begin
      blk_in <= blk_req;
    end
  end
endmodule

// ---- dv/uvs_stage_tb_top.sv ----
// self-checking bench for the undervoltage stage timing block
// assumes the block model beside it and a shortened tick divider
`timescale 1ns/1ps
module uvs_stage_tb_top;
  import uvs_pkg::*;
  // ----------------
  // signals
  // ----------------
  localparam int TK = 256;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  uvs_meas_t meas = {3{16'h1B58}};
  logic blk_req = 1'b0;
  logic blk_in;
  uvs_flags_t flags;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;

  always #4 clk = ~clk;
  // phase count follows the enabled cycles, so ticks stay predictable
  always @(posedge clk) cyc <= rst ? 0 : cyc + (ce ? 1 : 0);

  uvs_stage #(.TICK_CLKS(TK)) DUT (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .meas(meas), .blk_in(blk_in), .flags(flags));
  uvs_blk_model u_blk (.clk(clk), .rst(rst), .blk_req(blk_req), .blk_in(blk_in));

  // ----------------
  // shared tasks
  // ----------------
  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so it is taken mid-cycle
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(name, exp, rdata);
    @(posedge clk);
  endtask

  // stops late in a tick: flags settled, new inputs caught next tick
  task automatic step(input int n);
    int j;
    for (int i = 0; i < n; i++) begin
      j = 0;
      do begin
        @(posedge clk);
        j++;
      end while (cyc % TK != 240 && j < 300);
      if (j >= 300) begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask

  task automatic fl(input logic [2:0] e);
    chk("flags", {29'h0, e}, {29'h0, flags});
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs();
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rreg(A_CTRL, {28'h0, CTRL_RST}, "ctrl");
    rreg(A_FIXED_DLY, {16'h0, FIXED_DLY_RST}, "delay");
    rreg(A_KDIAL, {16'h0, KDIAL_RST}, "dial");
    rreg(A_AEXP, {16'h0, AEXP_RST}, "exponent");
    rreg(A_REL, {16'h0, REL_RST}, "release");
    rreg(A_PLVL, 32'h0001D4C0, "pick level");
    rreg(A_BLVL, 32'h00004E20, "block level");
    wreg(A_STAT, 32'hFFFFFFFF);
    rreg(A_STAT, 32'h0, "status");
    rreg(8'h7C, 32'h0, "unmapped");
  endtask

  task automatic t_fixed();
    step(1);
    meas <= {16'h2EE0, 16'h2328, 16'h0BB8};
    step(1);
    fl(3'h4);
    rreg(A_TREM, 32'h7, "remaining");
    rreg(A_TEXP, 32'h8, "expected time");
    step(6);
    fl(3'h4);
    step(1);
    fl(3'h5);
    rreg(A_RAT0, 32'h32, "ratio0");
    rreg(A_RAT1, 32'h96, "ratio1");
    rreg(A_RAT2, 32'hC8, "ratio2");
    rreg(A_RMIN, 32'h32, "lowest");
    step(1);
    meas <= {3{16'h1B58}};
    step(10);
    chk("start", 32'h1, {31'h0, flags.start});
    step(4);
    chk("start", 32'h0, {31'h0, flags.start});
  endtask

  task automatic t_inst();
    wreg(A_FIXED_DLY, 32'h0);
    meas <= {3{16'h0BB8}};
    step(1);
    fl(3'h5);
    wreg(A_CTRL, 32'h4);
    meas <= {3{16'h1B58}};
    step(1);
    chk("start", 32'h0, {31'h0, flags.start});
  endtask

  task automatic t_blk();
    blk_req <= 1'b1;
    meas <= {3{16'h0BB8}};
    step(2);
    fl(3'h2);
    blk_req <= 1'b0;
    meas <= {3{16'h1B58}};
    wreg(A_FIXED_DLY, 32'h8);
    step(2);
    meas <= {3{16'h0BB8}};
    step(2);
    fl(3'h4);
    blk_req <= 1'b1;
    step(1);
    fl(3'h2);
    step(8);
    fl(3'h2);
    blk_req <= 1'b0;
    meas <= {3{16'h1B58}};
    step(2);
  endtask

  task automatic t_de();
    wreg(A_UBLK, 32'h0);
    meas <= {3{16'h01F4}};
    step(1);
    fl(3'h4);
    wreg(A_UBLK, 32'h3E8);
    meas <= {3{16'h1B58}};
    step(1);
    meas <= {3{16'h01F4}};
    step(2);
    fl(3'h2);
    meas <= {3{16'h170C}};
    step(2);
    fl(3'h2);
    meas <= {3{16'h1B58}};
    step(2);
  endtask

  task automatic t_inv();
    wreg(A_CTRL, 32'h7);
    meas <= {3{16'h0BB8}};
    step(2);
    rreg(A_TEXP, 32'h14, "expected time");
    meas <= {3{16'h1194}};
    step(1);
    rreg(A_TEXP, 32'h28, "expected time");
  endtask

  // second reset mid-run, then the timer keeps running through release
  task automatic t_cont();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wreg(A_CTRL, 32'hE);
    meas <= {3{16'h0BB8}};
    step(5);
    fl(3'h4);
    meas <= {3{16'h1B58}};
    step(3);
    fl(3'h4);
    step(1);
    fl(3'h5);
  endtask

  // ----------------
  // main sequence
  // ----------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fixed();
    t_inst();
    t_blk();
    t_de();
    t_inv();
    t_cont();
    report_and_stop();
  end
endmodule
